/* File: common/sfp_pkg.sv */
// types and constants for the streaming factory program sequencer
// assumes a 16-bit flash word interface and synchronous host strobes
package sfp_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 23;
    localparam int BUF_WORDS = 32;
    localparam int BUF_AW = 5;
    localparam int BLK_AW = 16;
    localparam int FIFO_DEPTH = 8;
    localparam logic [DATA_W-1:0] PAD_WORD = 16'hFFFF;
    localparam logic [BUF_AW-1:0] ALIGN_LOW = 5'h00;
    // status bit positions
    localparam int ST_READY = 7;
    localparam int ST_ESUSP = 6;
    localparam int ST_PROG_ERR = 4;
    localparam int ST_SUPPLY_ERR = 3;
    localparam int ST_PSUSP = 2;
    localparam int ST_LOCK_ERR = 1;
    localparam int ST_BUF_BUSY = 0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    // timing
    localparam int CLK_MHZ = 250;
    localparam int SETUP_NS = 500;
    localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int WORD_PROG_CYC = 4;
    localparam int SUSP_CYC = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } sfp_word_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_SETUP = 7'b0000010,
        S_FILL = 7'b0000100,
        S_PROG = 7'b0001000,
        S_SUSP_WAIT = 7'b0010000,
        S_SUSP = 7'b0100000,
        S_DRAIN = 7'b1000000
    } sfp_state_t;
endpackage

/* File: core/sfp_fifo.sv */
// flip-flop fifo with valid/ready on both sides
// assumes one clock, asynchronous active-high reset
`timescale 1ns/1ps
module sfp_fifo #(
    parameter int WIDTH = 39,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // read side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    // flush drops everything held
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
    } sfp_fifo_st_t;
    sfp_fifo_st_t st;
    sfp_fifo_st_t next_st;
    logic push;
    logic pop;

    assign in_ready = (st.cnt != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    assign out_valid = (st.cnt != '0);
    assign out_data = st.mem[st.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (flush) begin
            next_st.wr = '0;
            next_st.rd = '0;
            next_st.cnt = '0;
        end else begin
            if (push) begin
                next_st.mem[st.wr] = in_data;
                next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
            end
            if (pop) begin
                next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
            end
            if (push && !pop) begin
                next_st.cnt = st.cnt + 1'b1;
            end else if (pop && !push) begin
                next_st.cnt = st.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

/* File: core/sfp_sequencer.sv */
// streaming factory program sequencer of the write state machine
// assumes host strobes are synchronous to CLK; the array is modelled as a word write port
//
// Contract
// - unaligned start aborts, sets program fail
// - array address continues, wraps inside block
// - suspend ignored during streaming program
// - setup acceptance clears ready while checking
// - failed check sets fail, lock, supply bits
// - writes during streaming are buffer data
// - fixed 32-word fill from index zero
// - program only when buffer full; pad
// - out-of-block address mid-fill discards buffer
// - buffer busy set until array written
// - writes ignored while array programming runs
// - other-block 0xFFFF write enters exit; the code exits on any other-block write, whatever its data word
// - exit sets ready, keeps read mode
// - program suspend halts, sets ready and suspended
// - only reads and resume while suspended
// - resume clears ready and suspended bits
// - reset pin resets while suspended
// - low supply halts programming, sets supply bit
`timescale 1ns/1ps
module sfp_sequencer
    import sfp_pkg::*;
#(
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int PROG_CYCLES = WORD_PROG_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // host write port (decoded commands and data)
    input wire logic WR_STROBE,
    input wire sfp_pkg::sfp_word_t WR_WORD,
    output logic WR_READY,
    // decoded commands
    input wire logic CMD_STREAM_START,
    input wire logic CMD_PROG_SUSPEND,
    input wire logic CMD_RESUME,
    input wire logic CMD_CLEAR_STATUS,
    input wire logic CMD_OTHER,
    input wire logic PLAIN_PROG_START,
    // block and supply conditions
    input wire logic BLOCK_LOCKED,
    input wire logic SUPPLY_LOW,
    input wire logic SUPPLY_HIGH_OK,
    // status and mode
    output logic [7:0] STATUS_BITS,
    output logic STREAM_ACTIVE,
    output logic READ_MODE_STATUS,
    // array write port
    output logic ARRAY_WE,
    output logic [sfp_pkg::ADDR_W-1:0] ARRAY_ADDR,
    output logic [sfp_pkg::DATA_W-1:0] ARRAY_DATA
);
    import sfp_pkg::*;

    typedef struct packed {
        sfp_state_t state;
        sfp_state_t resume_to;
        logic [7:0] status;
        logic [ADDR_W-1:0] block_addr;
        logic [BLK_AW-1:0] offs;
        logic [BUF_WORDS-1:0][DATA_W-1:0] buffer;
        logic [BUF_AW:0] fill;
        logic [BUF_AW:0] prog_idx;
        logic [15:0] timer;
        logic stream;
        logic rd_status;
        logic we;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic wr_ready;
    } sfp_st_t;

    sfp_st_t st;
    sfp_st_t next_st;
    sfp_word_t f_word;
    logic f_valid;
    logic f_ready;
    logic f_in_ready;
    logic f_flush;
    logic in_block;

    // the fifo decouples host strobes from the fill logic; its ready goes back to the host
    sfp_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .rst(RST),
        .in_data(WR_WORD),
        .in_valid(WR_STROBE && st.state == S_FILL),
        .in_ready(f_in_ready),
        .out_data(f_word),
        .out_valid(f_valid),
        .out_ready(f_ready),
        .flush(f_flush)
    );

    assign in_block = (f_word.addr[ADDR_W-1:BLK_AW] == st.block_addr[ADDR_W-1:BLK_AW]);
    assign f_ready = (st.state == S_FILL);
    assign f_flush = (st.state != S_FILL);

    always_comb begin
        next_st = st;
        next_st.we = 1'b0;
        next_st.wr_ready = f_in_ready;
        if (CMD_CLEAR_STATUS && st.state == S_IDLE) begin
            next_st.status[ST_PROG_ERR] = 1'b0;
            next_st.status[ST_SUPPLY_ERR] = 1'b0;
            next_st.status[ST_LOCK_ERR] = 1'b0;
        end
        case (st.state)
            S_IDLE: begin
                if (CMD_STREAM_START) begin
                    next_st.block_addr = WR_WORD.addr;
                    next_st.offs = WR_WORD.addr[BLK_AW-1:0];
                    next_st.status[ST_READY] = 1'b0;
                    next_st.stream = 1'b1;
                    next_st.rd_status = 1'b1;
                    next_st.timer = 16'(SETUP_CYCLES);
                    next_st.fill = '0;
                    next_st.state = S_SETUP;
                end else if (PLAIN_PROG_START) begin
                    next_st.status[ST_READY] = 1'b0;
                    next_st.timer = 16'(PROG_CYCLES);
                    next_st.resume_to = S_DRAIN;
                    next_st.state = S_DRAIN;
                end
            end
            S_SETUP: begin
                if (st.timer > 16'h0001) begin
                    next_st.timer = st.timer - 16'h0001;
                end else if (BLOCK_LOCKED || !SUPPLY_HIGH_OK || SUPPLY_LOW
                             || st.block_addr[BUF_AW-1:0] != ALIGN_LOW) begin
                    next_st.status[ST_PROG_ERR] = 1'b1;
                    next_st.status[ST_LOCK_ERR] = BLOCK_LOCKED;
                    next_st.status[ST_SUPPLY_ERR] = !SUPPLY_HIGH_OK || SUPPLY_LOW;
                    next_st.status[ST_READY] = 1'b1;
                    next_st.stream = 1'b0;
                    next_st.state = S_IDLE;
                end else begin
                    next_st.status[ST_BUF_BUSY] = 1'b0;
                    next_st.state = S_FILL;
                end
            end
            S_FILL: begin
                // suspend has no effect here; ready stays low between fills
                if (f_valid) begin
                    if (!in_block) begin
                        // exit discards any partial fill; data word is not checked
                        next_st.fill = '0;
                        next_st.stream = 1'b0;
                        next_st.status[ST_READY] = 1'b1;
                        next_st.state = S_IDLE;
                    end else begin
                        next_st.buffer[st.fill[BUF_AW-1:0]] = f_word.data;
                        if (st.fill == (BUF_AW+1)'(BUF_WORDS - 1)) begin
                            next_st.fill = '0;
                            next_st.prog_idx = '0;
                            next_st.timer = 16'(PROG_CYCLES);
                            next_st.status[ST_BUF_BUSY] = 1'b1;
                            next_st.state = S_PROG;
                        end else begin
                            next_st.fill = st.fill + 1'b1;
                        end
                    end
                end
            end
            S_PROG: begin
                // host strobes are not queued here, so they are dropped
                if (SUPPLY_LOW) begin
                    next_st.status[ST_SUPPLY_ERR] = 1'b1;
                    next_st.status[ST_PROG_ERR] = 1'b1;
                    next_st.status[ST_READY] = 1'b1;
                    next_st.status[ST_BUF_BUSY] = 1'b0;
                    next_st.stream = 1'b0;
                    next_st.state = S_IDLE;
                end else if (st.timer > 16'h0001) begin
                    next_st.timer = st.timer - 16'h0001;
                end else begin
                    next_st.we = 1'b1;
                    next_st.waddr = {st.block_addr[ADDR_W-1:BLK_AW], st.offs};
                    next_st.wdata = st.buffer[st.prog_idx[BUF_AW-1:0]];
                    next_st.offs = st.offs + 1'b1;
                    next_st.timer = 16'(PROG_CYCLES);
                    if (st.prog_idx == (BUF_AW+1)'(BUF_WORDS - 1)) begin
                        next_st.status[ST_BUF_BUSY] = 1'b0;
                        next_st.state = S_FILL;
                    end else begin
                        next_st.prog_idx = st.prog_idx + 1'b1;
                    end
                end
            end
            S_DRAIN: begin
                // ordinary program: suspendable, supply checked
                if (SUPPLY_LOW) begin
                    next_st.status[ST_SUPPLY_ERR] = 1'b1;
                    next_st.status[ST_PROG_ERR] = 1'b1;
                    next_st.status[ST_READY] = 1'b1;
                    next_st.state = S_IDLE;
                end else if (CMD_PROG_SUSPEND) begin
                    next_st.resume_to = S_DRAIN;
                    next_st.state = S_SUSP_WAIT;
                end else if (st.timer > 16'h0001) begin
                    next_st.timer = st.timer - 16'h0001;
                end else begin
                    next_st.status[ST_READY] = 1'b1;
                    next_st.state = S_IDLE;
                end
            end
            S_SUSP_WAIT: begin
                // halt point reached after a short fixed latency
                next_st.status[ST_READY] = 1'b1;
                next_st.status[ST_PSUSP] = 1'b1;
                next_st.rd_status = 1'b1;
                next_st.state = S_SUSP;
            end
            S_SUSP: begin
                // other commands are not acted on here
                if (CMD_RESUME) begin
                    next_st.status[ST_READY] = 1'b0;
                    next_st.status[ST_PSUSP] = 1'b0;
                    next_st.state = st.resume_to;
                end
            end
            default: begin
                next_st.state = S_IDLE;
            end
        endcase
        if (CMD_OTHER && st.state == S_IDLE) begin
            next_st.rd_status = 1'b0; // other command in idle leaves status read mode
        end
    end

    // reset pin returns everything to idle with only ready set, suspended or not
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
            st.state <= S_IDLE;
            st.resume_to <= S_IDLE;
            st.status <= STATUS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign STATUS_BITS = st.status;
    assign STREAM_ACTIVE = st.stream;
    assign READ_MODE_STATUS = st.rd_status;
    assign ARRAY_WE = st.we;
    assign ARRAY_ADDR = st.waddr;
    assign ARRAY_DATA = st.wdata;
    assign WR_READY = st.wr_ready;
endmodule

/* File: verification/sfp_sequencer_sva.sv */
// port checker for the streaming program sequencer
// assumes one CLK domain and PROG_CYCLES left at its default of 4
`timescale 1ns/1ps
module sfp_sequencer_sva
    import sfp_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // commands
    input wire logic CMD_STREAM_START,
    input wire logic CMD_PROG_SUSPEND,
    input wire logic CMD_RESUME,
    // status and array port
    input wire logic [7:0] STATUS_BITS,
    input wire logic STREAM_ACTIVE,
    input wire logic ARRAY_WE,
    input wire logic [sfp_pkg::ADDR_W-1:0] ARRAY_ADDR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_start_busy: assert property (
        CMD_STREAM_START && STATUS_BITS[7] && !STATUS_BITS[2] |=> !STATUS_BITS[7])
        else $error("ready still set after stream start");
    chk_ready_held: assert property (
        STREAM_ACTIVE |-> !STATUS_BITS[7]) else $error("ready set while streaming");
    chk_no_suspend: assert property (
        STREAM_ACTIVE |-> !STATUS_BITS[2]) else $error("streaming program got suspended");
    chk_we_spacing: assert property (
        ARRAY_WE && STREAM_ACTIVE |=> !ARRAY_WE [*3]) else $error("array writes too close");
    chk_addr_step: assert property (
        (ARRAY_WE && STREAM_ACTIVE ##1 !ARRAY_WE [*3] ##1 ARRAY_WE)
        |-> {ARRAY_ADDR[22:16], 16'(ARRAY_ADDR[15:0] - 16'h0001)} == $past(ARRAY_ADDR, 4))
        else $error("array address did not step inside the block");
    chk_suspend_set: assert property (
        CMD_PROG_SUSPEND && !STATUS_BITS[7] && !STREAM_ACTIVE
        |-> ##[1:4] (STATUS_BITS[7] && STATUS_BITS[2])) else $error("suspend not flagged");
    chk_resume_clear: assert property (
        CMD_RESUME && STATUS_BITS[2] |=> !STATUS_BITS[7] && !STATUS_BITS[2])
        else $error("resume left suspend flags set");
    chk_exit_ready: assert property (
        $fell(STREAM_ACTIVE) |-> STATUS_BITS[7]) else $error("exit without ready");
endmodule

bind sfp_sequencer sfp_sequencer_sva chk (.CLK(CLK), .RST(RST),
    .CMD_STREAM_START(CMD_STREAM_START), .CMD_PROG_SUSPEND(CMD_PROG_SUSPEND),
    .CMD_RESUME(CMD_RESUME), .STATUS_BITS(STATUS_BITS), .STREAM_ACTIVE(STREAM_ACTIVE),
    .ARRAY_WE(ARRAY_WE), .ARRAY_ADDR(ARRAY_ADDR));

/* File: verification/sfp_host_model.sv */
// host programmer model: presents the block start and strobes words in
// assumes the caller waits for the fill phase and for buffer busy to clear
`timescale 1ns/1ps
module sfp_host_model
    import sfp_pkg::*;
(
    // clock
    input wire logic CLK,
    // write port
    input wire logic WR_READY,
    output logic WR_STROBE,
    output sfp_pkg::sfp_word_t WR_WORD
);
    initial begin
        WR_STROBE = 1'b0;
        WR_WORD = '0;
    end
    task automatic present(input logic [ADDR_W-1:0] a);
        WR_WORD = '{addr: a, data: PAD_WORD};
    endtask
    // one idle edge first, so a strobe is never lowered and raised in one step
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge CLK);
        #1;
        while (!WR_READY) begin
            @(posedge CLK);
            #1;
        end
        WR_WORD = '{addr: a, data: d};
        WR_STROBE = 1'b1;
        @(posedge CLK);
        #1;
        WR_STROBE = 1'b0;
        WR_WORD.data = ~d;
    endtask
endmodule

/* File: verification/sfp_sequencer_bench.sv */
// self-checking bench for the streaming program sequencer
// assumes the checker is bound and the host model drives the write port
`timescale 1ns/1ps
module sfp_sequencer_bench;
    import sfp_pkg::*;
    localparam logic [ADDR_W-1:0] BASE = 23'h05FFE0;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [5:0] cmd = '0;
    logic lock = 1'b0, low = 1'b0, high = 1'b1;
    logic strobe, wr_ready, active, rd_mode, we;
    sfp_word_t word;
    logic [7:0] st;
    logic [ADDR_W-1:0] a_addr;
    logic [DATA_W-1:0] a_data;
    int n_errors = 0, checks_done = 0, n_we = 0;
    always #2 CLK = ~CLK;
    sfp_sequencer #(.SETUP_CYCLES(2)) uut (.CLK(CLK), .RST(RST), .WR_STROBE(strobe),
        .WR_WORD(word), .WR_READY(wr_ready), .CMD_STREAM_START(cmd[0]),
        .CMD_PROG_SUSPEND(cmd[1]), .CMD_RESUME(cmd[2]), .CMD_CLEAR_STATUS(cmd[3]),
        .CMD_OTHER(cmd[4]), .PLAIN_PROG_START(cmd[5]), .BLOCK_LOCKED(lock),
        .SUPPLY_LOW(low), .SUPPLY_HIGH_OK(high), .STATUS_BITS(st), .STREAM_ACTIVE(active),
        .READ_MODE_STATUS(rd_mode), .ARRAY_WE(we), .ARRAY_ADDR(a_addr), .ARRAY_DATA(a_data));
    sfp_host_model host (.CLK(CLK), .WR_READY(wr_ready), .WR_STROBE(strobe), .WR_WORD(word));
    function automatic logic [DATA_W-1:0] exp_data(input int n);
        return (n < 52) ? 16'(32'h1000 + n) : PAD_WORD;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        checks_done++;
        if ((got & m) !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic pulse(input int i);
        cmd[i] = 1'b1;
        cyc(1);
        cmd[i] = 1'b0;
    endtask
    task automatic wait_bit(input int b, input logic v);
        for (int k = 0; k < 400 && st[b] !== v; k++) cyc(1);
        chk(32'(st), 32'(v) << b, 32'h1 << b);
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // sampled mid-cycle, away from the edge that updates the array port
    always @(negedge CLK) begin
        if (!RST && we && active) begin
            chk(32'(a_addr), {9'h0, BASE[22:16], 16'(BASE[15:0] + n_we[15:0])}, '1);
            chk(32'(a_data), 32'(exp_data(n_we)), '1);
            n_we++;
        end
    end
    task automatic t_setup_errors();
        logic [7:0] want [3] = '{8'h92, 8'h98, 8'h90};
        for (int k = 0; k < 3; k++) begin
            lock = (k == 0);
            high = (k != 1);
            host.present(k == 2 ? BASE | 23'h3 : BASE);
            pulse(0);
            chk(32'(st), 32'h0, 32'h80);
            cyc(6);
            chk(32'(st), 32'(want[k]), 32'hFF);
            pulse(3);
            cyc(2);
            chk(32'(st), 32'(STATUS_RESET), 32'hFF);
        end
        lock = 1'b0;
        high = 1'b1;
        $display("test setup_errors done");
    endtask
    task automatic t_stream();
        logic mode;
        pulse(4);
        chk(32'(rd_mode), 32'h0, '1);
        host.present(BASE);
        pulse(0);
        chk(32'(rd_mode), 32'h1, '1);
        cyc(4);
        chk(32'(st), 32'h0, 32'h81);
        mode = rd_mode;
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 32; i++) host.put(BASE, exp_data(b * 32 + i));
            wait_bit(0, 1'b1);
            pulse(1);
            host.put(BASE, 16'h0BAD);
            wait_bit(0, 1'b0);
            chk(32'(st), 32'h0, 32'h84);
        end
        // the last array write is only counted at the next falling edge
        cyc(1);
        chk(32'(n_we), 32'd64, '1);
        for (int i = 0; i < 5; i++) host.put(BASE, 16'h2000);
        host.put({7'h06, 16'h0000}, PAD_WORD);
        cyc(3);
        chk({24'h0, st[7], 6'h0, active}, 32'h80, '1);
        chk(32'(rd_mode), 32'(mode), '1);
        cyc(40);
        chk(32'(n_we), 32'd64, '1);
        $display("test stream done");
    endtask
    task automatic t_suspend();
        pulse(5);
        pulse(1);
        cyc(3);
        chk(32'(st), 32'h84, 32'h84);
        pulse(4);
        pulse(5);
        cyc(1);
        chk(32'(st), 32'h84, 32'h84);
        chk(32'(rd_mode), 32'h1, '1);
        pulse(2);
        cyc(1);
        chk(32'(st), 32'h0, 32'h84);
        wait_bit(7, 1'b1);
        pulse(5);
        pulse(1);
        cyc(3);
        RST = 1'b1;
        cyc(1);
        RST = 1'b0;
        chk(32'(st), 32'(STATUS_RESET), 32'hFF);
        $display("test suspend done");
    endtask
    task automatic t_supply();
        pulse(5);
        low = 1'b1;
        cyc(6);
        chk(32'(st), 32'h98, 32'h98);
        low = 1'b0;
        pulse(3);
        cyc(1);
        chk(32'(st), 32'(STATUS_RESET), 32'hFF);
        // low supply while a full buffer is being programmed
        host.present(BASE);
        pulse(0);
        cyc(4);
        for (int i = 0; i < 32; i++) host.put(BASE, PAD_WORD);
        wait_bit(0, 1'b1);
        low = 1'b1;
        cyc(2);
        chk(32'(st), 32'h98, 32'hFF);
        chk(32'(active), 32'h0, '1);
        low = 1'b0;
        pulse(3);
        cyc(1);
        chk(32'(st), 32'(STATUS_RESET), 32'hFF);
        $display("test supply done");
    endtask
    // whole run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge CLK);
        n_errors++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end
    initial begin
        cyc(6);
        RST = 1'b0;
        chk(32'(st), 32'(STATUS_RESET), 32'hFF);
        t_setup_errors();
        t_stream();
        t_suspend();
        t_supply();
        conclude();
    end
endmodule
